// file: asp_pkg.sv
`default_nettype none
package asp_pkg;
  // timing
  localparam int CLK_HZ     = 100_000_000;
  localparam int MCLK_HZ    = 614_400;
  localparam int RESET_MCLK = 90;
  localparam int EXIT_MCLK  = 130;
  localparam int RESET_CYC  = int'((longint'(RESET_MCLK) * CLK_HZ + MCLK_HZ - 1) / MCLK_HZ);
  localparam int EXIT_CYC   = int'((longint'(EXIT_MCLK) * CLK_HZ + MCLK_HZ - 1) / MCLK_HZ);
  localparam int ONES_RESET = 64;
  // sizes
  localparam int DATA_W     = 24;
  localparam int FIFO_DEPTH = 32;
  // register addresses
  localparam logic [5:0] ADDR_STATUS = 6'h00;
  localparam logic [5:0] ADDR_CTRL   = 6'h01;
  localparam logic [5:0] ADDR_DATA   = 6'h02;
  localparam logic [5:0] ADDR_CHAN   = 6'h09;
  // transfer lengths in bits
  localparam logic [5:0] LEN_DEF     = 6'h08;
  localparam logic [5:0] LEN_CTRL    = 6'h10;
  localparam logic [5:0] LEN_DATA    = 6'h18;
  localparam logic [5:0] LEN_DATA_ST = 6'h20;
  // communications byte
  localparam int         CMD_WEN_BIT = 7;
  localparam int         CMD_RD_BIT  = 6;
  localparam logic [7:0] CMD_DATA_RD = 8'h42;
  // control register
  localparam int          CTRL_CONTINUOUS_READOUT_ENABLE   = 11;
  localparam int          CTRL_DATA_STATUS = 10;
  localparam int          CTRL_CS_EN       = 9;
  localparam int          CTRL_MODE_LSB    = 2;
  localparam logic [15:0] CTRL_RST         = 16'h0000;
  localparam logic [15:0] CHAN_RST         = 16'h0001;
  localparam logic [3:0]  MODE_CONT        = 4'h0;
  localparam logic [3:0]  MODE_SINGLE      = 4'h1;
  localparam logic [3:0]  MODE_STANDBY     = 4'h2;
  // status register
  localparam int STAT_RDY = 7;
  localparam int STAT_POR = 4;
  // states
  typedef enum logic [1:0] {SP_CMD, SP_WR, SP_RD, SP_CRD} asp_ser_t;
  typedef enum logic [2:0] {CV_RESET, CV_IDLE, CV_EXIT, CV_START, CV_WAIT, CV_WARN, CV_UPD, CV_STBY} asp_cv_t;
endpackage
`default_nettype wire

// file: asp_sync.sv
`timescale 1ns/10ps
`default_nettype none
module asp_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  // level in and out
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta <= RST;
      o_q  <= RST;
    end else begin
      meta <= i_d;
      o_q  <= meta;
    end
  end
endmodule
`default_nettype wire

// file: asp_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module asp_fifo #(
  parameter int W     = 24,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  // fill side
  input  wire logic         i_wr_valid,
  output logic              o_wr_ready,
  input  wire logic [W-1:0] i_wr_data,
  // drain side
  output logic              o_rd_valid,
  input  wire logic         i_rd_ready,
  output logic      [W-1:0] o_rd_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic [AW:0]   next_count;
  logic          push;
  logic          take;

  assign push = i_wr_valid && o_wr_ready;
  // refill the output register when it is empty or being drained
  assign take = (count != '0) && (!o_rd_valid || i_rd_ready);

  always_comb begin
    next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, take};
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_wr_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr     <= '0;
      rd_ptr     <= '0;
      count      <= '0;
      o_wr_ready <= 1'b1;
      o_rd_valid <= 1'b0;
      o_rd_data  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= AW'(wr_ptr + 1'b1);
      end
      if (take) begin
        o_rd_data <= mem[rd_ptr];
        rd_ptr    <= AW'(rd_ptr + 1'b1);
      end
      o_rd_valid <= take || (o_rd_valid && !i_rd_ready);
      count      <= next_count;
      o_wr_ready <= next_count != (AW+1)'(DEPTH);
    end
  end
endmodule
`default_nettype wire

// file: asp_top.sv
// Contract
// - after any reset only a communications write is accepted first
// - communications byte selects read or write and the target register
// - data in on din, out on shared pin, timed by host clock
// - ready pin falls on new word, rises when a data read completes
// - ready pin goes high before the data register updates
// - three-wire use with select tied low, host polls status ready bit
// - data word may be reread outside continuous readout, once inside
// - select falling edge presents the msb; clock may run between frames
// - a run of ones on din resets interface to await command
// - single mode converts once, readies, enters standby; exit takes 130 mclk
// - single mode with several channels converts each once then idles
// - ready high from result arrival until the word updates outside a data register read
// - append bit adds status to data reads; low four bits give channel
// - continuous mode at power-up; status ready bit falls each conversion
// - new word is discarded while the data register is being read
// - continuous mode cycles enabled channels low to high then wraps
// - continuous readout reloads the output register with each new result
// - in continuous readout only 0x42 while ready and ones reset work
// - select rising edge resets interface to await a command, except in continuous readout
// - 64 ones restore control and channel registers; reset lasts 90 mclk
`timescale 1ns/10ps
`default_nettype none
module asp_top #(
  parameter int RESET_CYC = asp_pkg::RESET_CYC,
  parameter int EXIT_CYC  = asp_pkg::EXIT_CYC
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // serial pins
  input  wire logic        i_cs_n,
  input  wire logic        i_sclk,
  input  wire logic        i_din,
  output logic             o_dout_rdy,
  output logic             o_dout_oe,
  // converter front end
  output logic             o_conv_start,
  output logic [3:0]       o_conv_chan,
  input  wire logic        i_res_valid,
  input  wire logic [23:0] i_res_data,
  output logic             o_res_ready,
  // status
  output logic             o_standby,
  output logic             o_reset_busy,
  output logic             o_continuous_readout_enable
);
  localparam int DW = asp_pkg::DATA_W;

  logic [2:0]       pin_s;
  logic             cs_n_s;
  logic             sclk_s;
  logic             din_s;
  logic             sclk_d;
  logic             cs_d;
  logic             rise;
  logic             fall;
  logic             cs_rise;
  asp_pkg::asp_ser_t ser_state;
  asp_pkg::asp_cv_t  cv_state;
  logic [5:0]       bit_cnt;
  logic [5:0]       len;
  logic [5:0]       addr;
  logic [5:0]       ones;
  logic [23:0]      in_sr;
  logic [31:0]      out_sr;
  logic             hold;
  logic             crd_word;
  logic             ctrl_wr;
  logic             rd_done;
  logic             crd_exit;
  logic             soft_rst;
  logic [15:0]      ctrl;
  logic [15:0]      chan_en;
  logic [DW-1:0]    data_reg;
  logic [3:0]       data_chan;
  logic             rdy_n;
  logic [15:0]      timer;
  logic [3:0]       cur_chan;
  logic [DW-1:0]    conv_word;
  logic             res_valid;
  logic [DW-1:0]    res_data;
  logic             res_pop;
  logic [7:0]       status;
  logic [7:0]       stat_new;
  logic [7:0]       cmd_byte;
  logic [23:0]      wr_val;
  logic             last_bit;
  logic [31:0]      rd_val;
  logic [5:0]       rd_len;
  logic [3:0]       mode;
  logic [3:0]       first_ch;
  logic [3:0]       nxt_ch;
  logic             has_nxt;
  logic             upd;
  logic             discard;
  logic             upd_ok;

  asp_sync #(.W(3), .RST(3'h6)) u_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_d     ({i_cs_n, i_sclk, i_din}),
    .o_q     (pin_s)
  );

  asp_fifo #(.W(DW), .DEPTH(asp_pkg::FIFO_DEPTH)) u_fifo (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_wr_valid (i_res_valid),
    .o_wr_ready (o_res_ready),
    .i_wr_data  (i_res_data),
    .o_rd_valid (res_valid),
    .i_rd_ready (res_pop),
    .o_rd_data  (res_data)
  );

  assign {cs_n_s, sclk_s, din_s} = pin_s;
  assign rise     = sclk_s && !sclk_d && !cs_n_s;
  assign fall     = !sclk_s && sclk_d && !cs_n_s;
  assign cs_rise  = cs_n_s && !cs_d;
  assign cmd_byte = {in_sr[6:0], din_s};
  assign wr_val   = {in_sr[22:0], din_s};
  assign last_bit = bit_cnt == len - 6'h01;
  assign mode     = ctrl[asp_pkg::CTRL_MODE_LSB +: 4];
  assign res_pop  = cv_state == asp_pkg::CV_WAIT;
  assign upd      = cv_state == asp_pkg::CV_UPD;
  assign discard  = ser_state == asp_pkg::SP_RD && addr == asp_pkg::ADDR_DATA;
  assign upd_ok   = upd && !discard;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sclk_d <= 1'b1;
      cs_d   <= 1'b1;
    end else begin
      sclk_d <= sclk_s;
      cs_d   <= cs_n_s;
    end
  end

  // status words; low nibble is the channel of the word
  always_comb begin
    status                    = '0;
    status[asp_pkg::STAT_RDY] = rdy_n;
    status[asp_pkg::STAT_POR] = cv_state == asp_pkg::CV_RESET;
    status[3:0]               = data_chan;
    stat_new                  = '0;
    stat_new[3:0]             = cur_chan;
  end

  // read value, left aligned, and length per address
  always_comb begin
    rd_val = '0;
    rd_len = asp_pkg::LEN_DEF;
    case (cmd_byte[5:0])
      asp_pkg::ADDR_STATUS: rd_val = {status, 24'h00_0000};
      asp_pkg::ADDR_CTRL: begin
        rd_val = {ctrl, 16'h0000};
        rd_len = asp_pkg::LEN_CTRL;
      end
      asp_pkg::ADDR_DATA: begin
        rd_val = {data_reg, status};
        rd_len = ctrl[asp_pkg::CTRL_DATA_STATUS] ? asp_pkg::LEN_DATA_ST : asp_pkg::LEN_DATA;
      end
      asp_pkg::ADDR_CHAN: begin
        rd_val = {chan_en, 16'h0000};
        rd_len = asp_pkg::LEN_CTRL;
      end
      default: rd_val = '0;
    endcase
  end

  // ones detector
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ones     <= '0;
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= 1'b0;
      if (rise) begin
        if (!din_s) begin
          ones <= '0;
        end else if (ones == 6'(asp_pkg::ONES_RESET - 1)) begin
          ones     <= '0;
          soft_rst <= 1'b1;
        end else begin
          ones <= ones + 6'h01;
        end
      end
    end
  end

  // serial engine and register file
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ser_state <= asp_pkg::SP_CMD;
      bit_cnt   <= '0;
      len       <= asp_pkg::LEN_DEF;
      addr      <= '0;
      in_sr     <= '0;
      out_sr    <= '0;
      hold      <= 1'b0;
      crd_word  <= 1'b0;
      ctrl_wr   <= 1'b0;
      rd_done   <= 1'b0;
      crd_exit  <= 1'b0;
      ctrl      <= asp_pkg::CTRL_RST;
      chan_en   <= asp_pkg::CHAN_RST;
    end else begin
      ctrl_wr  <= 1'b0;
      rd_done  <= 1'b0;
      crd_exit <= 1'b0;
      if (soft_rst) begin
        ser_state <= asp_pkg::SP_CMD;
        bit_cnt   <= '0;
        hold      <= 1'b0;
        crd_word  <= 1'b0;
        ctrl      <= asp_pkg::CTRL_RST;
        chan_en   <= asp_pkg::CHAN_RST;
      end else if (cs_rise) begin
        bit_cnt <= '0;
        hold    <= 1'b0;
        if (ser_state != asp_pkg::SP_CRD) begin
          ser_state <= asp_pkg::SP_CMD;
        end
      end else if (upd_ok && ser_state == asp_pkg::SP_CRD) begin
        out_sr   <= {conv_word, stat_new};
        len      <= ctrl[asp_pkg::CTRL_DATA_STATUS] ? asp_pkg::LEN_DATA_ST : asp_pkg::LEN_DATA;
        bit_cnt  <= '0;
        crd_word <= 1'b1;
      end else if (fall && bit_cnt != '0 &&
                   (ser_state == asp_pkg::SP_RD || ser_state == asp_pkg::SP_CRD)) begin
        out_sr <= {out_sr[30:0], 1'b0};
      end else if (rise) begin
        in_sr   <= wr_val;
        bit_cnt <= bit_cnt + 6'h01;
        hold    <= 1'b0;
        unique case (ser_state)
          asp_pkg::SP_CMD: begin
            if (bit_cnt == 6'h07) begin
              bit_cnt <= '0;
              // bytes with the write-enable bit high are ignored
              if (!cmd_byte[asp_pkg::CMD_WEN_BIT]) begin
                addr <= cmd_byte[5:0];
                len  <= rd_len;
                if (cmd_byte[asp_pkg::CMD_RD_BIT]) begin
                  ser_state <= asp_pkg::SP_RD;
                  out_sr    <= rd_val;
                end else begin
                  ser_state <= asp_pkg::SP_WR;
                end
              end
            end
          end
          asp_pkg::SP_WR: begin
            if (last_bit) begin
              bit_cnt   <= '0;
              ser_state <= asp_pkg::SP_CMD;
              if (addr == asp_pkg::ADDR_CTRL) begin
                ctrl    <= wr_val[15:0];
                ctrl_wr <= 1'b1;
                if (wr_val[asp_pkg::CTRL_CONTINUOUS_READOUT_ENABLE]) begin
                  ser_state <= asp_pkg::SP_CRD;
                end
              end else if (addr == asp_pkg::ADDR_CHAN) begin
                chan_en <= wr_val[15:0];
              end
            end
          end
          asp_pkg::SP_RD: begin
            if (last_bit) begin
              bit_cnt   <= '0;
              ser_state <= asp_pkg::SP_CMD;
              hold      <= ctrl[asp_pkg::CTRL_CS_EN];
              rd_done   <= addr == asp_pkg::ADDR_DATA;
            end
          end
          asp_pkg::SP_CRD: begin
            if (bit_cnt == 6'h07 && cmd_byte == asp_pkg::CMD_DATA_RD && crd_word) begin
              ser_state                      <= asp_pkg::SP_CMD;
              ctrl[asp_pkg::CTRL_CONTINUOUS_READOUT_ENABLE]  <= 1'b0;
              crd_exit                       <= 1'b1;
              crd_word                       <= 1'b0;
              bit_cnt                        <= '0;
            end else if (last_bit) begin
              bit_cnt  <= '0;
              rd_done  <= crd_word;
              crd_word <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  // ready flag; a new word wins over a finished read
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdy_n <= 1'b1;
    end else if (soft_rst) begin
      rdy_n <= 1'b1;
    end else if (upd_ok) begin
      rdy_n <= 1'b0;
    end else if (cv_state == asp_pkg::CV_WARN || rd_done) begin
      rdy_n <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      data_reg  <= '0;
      data_chan <= '0;
    end else if (upd_ok) begin
      data_reg  <= conv_word;
      data_chan <= cur_chan;
    end
  end

  // channel sequencing
  always_comb begin
    first_ch = '0;
    nxt_ch   = '0;
    has_nxt  = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      if (chan_en[i]) begin
        first_ch = 4'(i);
      end
      if (chan_en[i] && 4'(i) > cur_chan) begin
        nxt_ch  = 4'(i);
        has_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cv_state     <= asp_pkg::CV_RESET;
      timer        <= '0;
      cur_chan     <= '0;
      conv_word    <= '0;
      o_conv_start <= 1'b0;
      o_conv_chan  <= '0;
    end else begin
      o_conv_start <= 1'b0;
      if (soft_rst) begin
        cv_state <= asp_pkg::CV_RESET;
        timer    <= '0;
      end else if (ctrl_wr) begin
        timer    <= '0;
        cur_chan <= first_ch;
        if (mode == asp_pkg::MODE_STANDBY) begin
          cv_state <= asp_pkg::CV_STBY;
        end else if (cv_state == asp_pkg::CV_STBY) begin
          cv_state <= asp_pkg::CV_EXIT;
        end else begin
          cv_state <= asp_pkg::CV_START;
        end
      end else begin
        unique case (cv_state)
          asp_pkg::CV_RESET: begin
            timer <= timer + 16'h0001;
            if (timer == 16'(RESET_CYC - 1)) begin
              cv_state <= asp_pkg::CV_START;
              cur_chan <= first_ch;
              timer    <= '0;
            end
          end
          asp_pkg::CV_EXIT: begin
            timer <= timer + 16'h0001;
            if (timer == 16'(EXIT_CYC - 1)) begin
              cv_state <= asp_pkg::CV_START;
              timer    <= '0;
            end
          end
          asp_pkg::CV_START: begin
            if (chan_en == '0) begin
              cv_state <= asp_pkg::CV_IDLE;
            end else begin
              o_conv_start <= 1'b1;
              o_conv_chan  <= cur_chan;
              cv_state     <= asp_pkg::CV_WAIT;
            end
          end
          asp_pkg::CV_WAIT: begin
            if (res_valid) begin
              conv_word <= res_data;
              cv_state  <= asp_pkg::CV_WARN;
            end
          end
          asp_pkg::CV_WARN: cv_state <= asp_pkg::CV_UPD;
          asp_pkg::CV_UPD: begin
            if (has_nxt) begin
              cur_chan <= nxt_ch;
              cv_state <= asp_pkg::CV_START;
            end else if (mode == asp_pkg::MODE_CONT) begin
              cur_chan <= first_ch;
              cv_state <= asp_pkg::CV_START;
            end else if (mode == asp_pkg::MODE_SINGLE && first_ch == cur_chan) begin
              cv_state <= asp_pkg::CV_STBY;
            end else begin
              cv_state <= asp_pkg::CV_IDLE;
            end
          end
          asp_pkg::CV_IDLE: cv_state <= asp_pkg::CV_IDLE;
          asp_pkg::CV_STBY: cv_state <= asp_pkg::CV_STBY;
        endcase
      end
    end
  end

  // pin and status outputs
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_dout_rdy   <= 1'b1;
      o_dout_oe    <= 1'b0;
      o_standby    <= 1'b0;
      o_reset_busy <= 1'b1;
      o_continuous_readout_enable  <= 1'b0;
    end else begin
      o_dout_oe <= !cs_n_s;
      if (ser_state == asp_pkg::SP_RD || hold || (ser_state == asp_pkg::SP_CRD && crd_word)) begin
        o_dout_rdy <= out_sr[31];
      end else begin
        o_dout_rdy <= rdy_n;
      end
      o_standby    <= cv_state == asp_pkg::CV_STBY;
      o_reset_busy <= cv_state == asp_pkg::CV_RESET;
      o_continuous_readout_enable  <= ctrl[asp_pkg::CTRL_CONTINUOUS_READOUT_ENABLE];
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  chk_warn_before_upd: assert property (upd |-> rdy_n)
    else $error("ready not high before data update");
  chk_ready_falls: assert property (upd_ok && !soft_rst |=> !rdy_n && data_reg == $past(conv_word))
    else $error("ready did not fall with new word");
  chk_read_raises: assert property (rd_done && !upd_ok && !soft_rst |=> rdy_n)
    else $error("ready not high after data read");
  chk_discard_word: assert property (upd && discard |=> $stable(data_reg))
    else $error("word not discarded during read");
  chk_cs_frame: assert property (cs_rise && !soft_rst && ser_state != asp_pkg::SP_CRD
                                  |=> ser_state == asp_pkg::SP_CMD)
    else $error("select rise did not reset interface");
  chk_ones_reset: assert property (rise && din_s && ones == 6'(asp_pkg::ONES_RESET - 1)
                                    |=> soft_rst ##1 (ser_state == asp_pkg::SP_CMD && ctrl == asp_pkg::CTRL_RST))
    else $error("ones run did not reset");
  chk_crd_reload: assert property (upd_ok && ser_state == asp_pkg::SP_CRD && !soft_rst && !cs_rise
                                    |=> bit_cnt == '0 && crd_word)
    else $error("readout register not reloaded");
  chk_crd_exit: assert property (crd_exit |-> !ctrl[asp_pkg::CTRL_CONTINUOUS_READOUT_ENABLE] && ser_state == asp_pkg::SP_CMD)
    else $error("continuous readout not left");
  chk_seq_chan: assert property (o_conv_start |-> chan_en[o_conv_chan] && $past(cv_state) == asp_pkg::CV_START)
    else $error("conversion on disabled channel");
  chk_exit_time: assert property (cv_state == asp_pkg::CV_EXIT && timer == 16'(EXIT_CYC - 1) && !ctrl_wr
                                   && !soft_rst |=> cv_state == asp_pkg::CV_START)
    else $error("standby exit time wrong");
  chk_pin_ready: assert property (ser_state == asp_pkg::SP_CMD && !hold && !cs_n_s
                                   |=> o_dout_oe && o_dout_rdy == $past(rdy_n))
    else $error("pin does not show ready");

  cov_crd_exit:  cover property (crd_exit);
  cov_discard:   cover property (upd && discard);
  cov_soft_rst:  cover property (soft_rst);
  cov_standby:   cover property (cv_state == asp_pkg::CV_STBY);
endmodule
`default_nettype wire

// file: asp_host.sv
`timescale 1ns/10ps
`default_nettype none
module asp_host (
  // serial pins
  output logic      o_cs_n,
  output logic      o_sclk,
  output logic      o_din,
  input  wire logic i_dout
);
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b1;
    o_din  = 1'b0;
  end
  // one framed transfer of n bits, msb first
  task automatic xfer(input int n, input logic [63:0] wd, output logic [63:0] rd);
    rd = '0;
    o_cs_n = 1'b0;
    #62.5;
    for (int i = n - 1; i >= 0; i--) begin
      o_sclk = 1'b0;
      o_din  = wd[i];
      #62.5;
      o_sclk = 1'b1;
      rd     = {rd[62:0], i_dout};
      #62.5;
    end
    o_din  = 1'b0;
    o_cs_n = 1'b1;
    #250;
  endtask
endmodule
`default_nettype wire

// file: tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam logic [23:0] WORD = 24'hA5_5A3C;
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        i_res_valid = 1'b1;
  logic [23:0] i_res_data = WORD;
  wire         cs_n, sclk, din, dout, oe, conv_start, res_ready, standby, rbusy, cread, pin;
  wire  [3:0]  conv_chan;
  logic [63:0] rd;
  logic [3:0]  prev;
  logic        have = 1'b0, seq_on = 1'b0, saw_busy = 1'b0;
  int          num_errors = 0, cmp_count = 0;
  logic [47:0] rows [3] = '{{8'h09, 8'h10, 16'h0005, 16'h0005},
                            {8'h05, 8'h08, 16'h005A, 16'h0000},
                            {8'h01, 8'h10, 16'h0200, 16'h0200}};
  event        fe_ev;
  assign pin = oe ? dout : 1'b1;
  always #5 i_clk = ~i_clk;
  asp_host host (.o_cs_n(cs_n), .o_sclk(sclk), .o_din(din), .i_dout(pin));
  asp_top #(.RESET_CYC(20), .EXIT_CYC(30)) uut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cs_n(cs_n), .i_sclk(sclk), .i_din(din),
    .o_dout_rdy(dout), .o_dout_oe(oe), .o_conv_start(conv_start), .o_conv_chan(conv_chan),
    .i_res_valid(i_res_valid), .i_res_data(i_res_data), .o_res_ready(res_ready),
    .o_standby(standby), .o_reset_busy(rbusy), .o_continuous_readout_enable(cread));
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input int ln, input logic [31:0] v);
    host.xfer(8 + ln, ({56'h0, a} << ln) | {32'h0, v}, rd);
  endtask
  task automatic rdr(input logic [7:0] a, input int ln);
    host.xfer(8 + ln, {56'h0, a | 8'h40} << ln, rd);
    rd = rd & ((64'h1 << ln) - 64'h1);
  endtask
  // front end: one word per 1001 cycles
  always begin
    @(posedge i_clk);
    if (i_rst_n && i_res_valid && res_ready) begin
      i_res_valid <= 1'b0;
      -> fe_ev;
      repeat (1000) @(posedge i_clk);
      i_res_valid <= 1'b1;
    end
  end
  always @(posedge i_clk) begin
    if (rbusy) saw_busy <= 1'b1;
    if (seq_on && conv_start) begin
      if (have) chk("chan", conv_chan, prev ^ 4'h2);
      prev <= conv_chan;
      have <= 1'b1;
    end else if (!seq_on) begin
      have <= 1'b0;
    end
  end
  initial begin
    repeat (3) @(posedge i_clk);
    chk("rst_oe", oe, 0);
    chk("rst_busy", rbusy, 1);
    chk("rst_cread", cread, 0);
    chk("rst_ready", res_ready, 1);
    i_rst_n <= 1'b1;
    repeat (60) @(posedge i_clk);
    chk("busy_end", rbusy, 0);
    for (int k = 0; k < 3; k++) begin
      wr(rows[k][47:40], int'(rows[k][39:32]), {16'h0, rows[k][31:16]});
      rdr(rows[k][47:40], int'(rows[k][39:32]));
      chk("reg", rd, {48'h0, rows[k][15:0]});
    end
    seq_on = 1'b1;
    repeat (2) begin
      rdr(8'h02, 24);
      chk("data", rd, {40'h0, WORD});
    end
    // two more starts checked before the control write restarts the sequence
    repeat (2) @(fe_ev);
    repeat (10) @(posedge i_clk);
    seq_on = 1'b0;
    wr(8'h01, 16, 32'h0600);
    rdr(8'h02, 32);
    chk("app_data", rd[31:8], WORD);
    chk("app_chan", rd[3:0] & 4'hD, 0);
    saw_busy = 1'b0;
    host.xfer(64, {64{1'b1}}, rd);
    chk("soft_busy", saw_busy, 1);
    rdr(8'h09, 16);
    chk("soft_chan", rd, 64'h0001);
    wr(8'h01, 16, 32'h0004);
    for (int t = 0; t < 3000 && standby !== 1'b1; t++) @(posedge i_clk);
    chk("standby", standby, 1);
    rdr(8'h00, 8);
    chk("stat_rdy", rd, 64'h0);
    wr(8'h01, 16, 32'h0800);
    chk("cread_on", cread, 1);
    @(fe_ev);
    repeat (10) @(posedge i_clk);
    host.xfer(24, 64'h0, rd);
    chk("cr_data", rd[23:0], WORD);
    @(fe_ev);
    repeat (10) @(posedge i_clk);
    host.xfer(8, 64'h42, rd);
    repeat (5) @(posedge i_clk);
    chk("cr_exit", cread, 0);
    wrap_up();
  end
  initial begin
    #800_000;
    num_errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
